/* File: design/tzm_defines.vh */
// How it works
// - Bias thermistor 25 ms every 225 ms
// - Bias always runs while input supply present
// - Profile select: four-zone, hot/cold, disabled
// - Hot or cold suspends charging and timers
// - Cool zone scales current, code 111 eighth
// - Scaled current rounds down to whole steps
// - Warm zone lowers regulation voltage to setting
// - A fault gives one 128 us pulse unless a pulse is already running
// - Fault flags stay set until host read
// - Interrupt on every threshold crossing
// - Above open threshold disables charging
// - Converter full scale fixed at 1.2 V
// - Reset thresholds 0.585/0.514/0.265/0.185 V
// - Eight-bit thresholds against result upper byte
// - Result readable with supply or battery
// - Aux input biased and sampled like thermistor
`ifndef TZM_DEFINES_VH
`define TZM_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TZM_CLK_MHZ      100
`define TZM_PERIOD_MS    225
`define TZM_BIAS_MS      25
`define TZM_PULSE_US     128

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TZM_A_COLD       4'h0
`define TZM_A_COOL       4'h1
`define TZM_A_WARM       4'h2
`define TZM_A_HOT        4'h3
`define TZM_A_ADJ        4'h4
`define TZM_A_CTRL       4'h5
`define TZM_A_FLAGS      4'h6
`define TZM_A_ZONE       4'h7
`define TZM_A_TS_HI      4'h8
`define TZM_A_TS_LO      4'h9
`define TZM_A_AUX_HI     4'ha
`define TZM_A_AUX_LO     4'hb
`define TZM_UNMAPPED     8'hff

// ----------------------------------------
// Reset values (1.2 V full scale, 256 steps)
// ----------------------------------------
`define TZM_RST_COLD     8'h7c
`define TZM_RST_COOL     8'h6d
`define TZM_RST_WARM     8'h38
`define TZM_RST_HOT      8'h27
`define TZM_OPEN_TH      8'hc0
`define TZM_RST_ADJ      8'h00
`define TZM_RST_CTRL     8'h00

// ----------------------------------------
// Fields
// ----------------------------------------
`define TZM_ADJ_SCALE    2:0
`define TZM_ADJ_VREG     6:4
`define TZM_CTRL_MODE    1:0
`define TZM_CTRL_AUX     2
`define TZM_CTRL_BATBIAS 3
`define TZM_MODE_FOUR    2'h0
`define TZM_MODE_HOTCOLD 2'h1
`define TZM_SCALE_FULL   4'h8

// ----------------------------------------
// Zones
// ----------------------------------------
`define TZM_Z_NORMAL     3'h0
`define TZM_Z_COLD       3'h1
`define TZM_Z_COOL       3'h2
`define TZM_Z_WARM       3'h3
`define TZM_Z_HOT        3'h4
`define TZM_Z_OPEN       3'h5

`endif

/* File: design/tzm_cnt.v */
`include "tzm_defines.vh"

module tzm_cnt #(
	parameter WIDTH = 25,
	parameter MAX   = 25'd22500000
) (
	input  wire             clk,
	input  wire             rst_b,
	input  wire             en,
	input  wire             clr,
	output wire [WIDTH-1:0] cnt,
	output wire             wrap
);

	reg [WIDTH-1:0] cnt_q;

	assign cnt  = cnt_q;
	assign wrap = en & (cnt_q == MAX - 1'b1);

	always @(posedge clk) begin
		if (!rst_b || clr) begin
			cnt_q <= {WIDTH{1'b0}};
		end else if (wrap) begin
			cnt_q <= {WIDTH{1'b0}};
		end else if (en) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule

/* File: design/tzm_zone.v */
`include "tzm_defines.vh"

module tzm_zone (
	input  wire [7:0] code,
	input  wire [7:0] cold_th,
	input  wire [7:0] cool_th,
	input  wire [7:0] warm_th,
	input  wire [7:0] hot_th,
	output reg  [2:0] zone
);

	// ----------------------------------------
	// Voltage falls as temperature rises
	// ----------------------------------------
	always @* begin
		if (code > `TZM_OPEN_TH) begin
			zone = `TZM_Z_OPEN;
		end else if (code > cold_th) begin
			zone = `TZM_Z_COLD;
		end else if (code > cool_th) begin
			zone = `TZM_Z_COOL;
		end else if (code < hot_th) begin
			zone = `TZM_Z_HOT;
		end else if (code < warm_th) begin
			zone = `TZM_Z_WARM;
		end else begin
			zone = `TZM_Z_NORMAL;
		end
	end

endmodule

/* File: design/tzm_top.v */
`include "tzm_defines.vh"

module tzm_top #(
	parameter PERIOD_CYC = `TZM_PERIOD_MS * 1000 * `TZM_CLK_MHZ,
	parameter BIAS_CYC   = `TZM_BIAS_MS * 1000 * `TZM_CLK_MHZ,
	parameter PULSE_CYC  = `TZM_PULSE_US * `TZM_CLK_MHZ
) (
	input  wire        CLK,
	input  wire        RST_B,
	input  wire        INPUT_SUPPLY_OK,
	input  wire        BATTERY_SUPPLY_OK,
	input  wire [7:0]  FAST_CHARGE_CURRENT_CODE,
	input  wire        TS_DONE,
	input  wire [15:0] TS_CODE,
	input  wire        AUX_DONE,
	input  wire [15:0] AUX_CODE,
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [3:0]  REG_ADDR,
	input  wire [7:0]  REG_WDATA,
	output reg  [7:0]  REG_RDATA,
	output reg         TS_BIAS_EN,
	output reg         AUX_BIAS_EN,
	output reg         SAMPLE_REQ,
	output reg         CHARGE_SUSPEND,
	output reg         SAFETY_TIMER_SUSPEND,
	output reg         CHARGE_DISABLE,
	output reg  [7:0]  CHARGE_CURRENT_CODE,
	output reg         VREG_REDUCE,
	output reg  [2:0]  VREG_ADJ_CODE,
	output reg         INT_PULSE
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg [7:0]  cold_q;
	reg [7:0]  cool_q;
	reg [7:0]  warm_q;
	reg [7:0]  hot_q;
	reg [7:0]  adj_q;
	reg [7:0]  ctrl_q;
	reg [5:0]  flags_q;
	reg [5:0]  flags_d;
	reg [15:0] ts_res_q;
	reg [15:0] aux_res_q;
	reg [2:0]  ts_zone_q;
	reg [2:0]  aux_zone_q;
	reg        ts_valid_q;
	reg        aux_valid_q;
	reg [7:0]  rdata_d;

	wire [1:0] mode       = ctrl_q[`TZM_CTRL_MODE];
	wire       aux_en     = ctrl_q[`TZM_CTRL_AUX];
	wire       mode_four  = (mode == `TZM_MODE_FOUR);
	wire       mode_hc    = (mode == `TZM_MODE_HOTCOLD);
	wire       mode_on    = mode_four | mode_hc;
	wire       powered    = INPUT_SUPPLY_OK | BATTERY_SUPPLY_OK;
	wire       wr_ok      = REG_WR & powered;
	wire       flags_rd   = REG_RD & (REG_ADDR == `TZM_A_FLAGS);

	always @(posedge CLK) begin
		if (!RST_B) begin
			cold_q <= `TZM_RST_COLD;
			cool_q <= `TZM_RST_COOL;
			warm_q <= `TZM_RST_WARM;
			hot_q  <= `TZM_RST_HOT;
			adj_q  <= `TZM_RST_ADJ;
			ctrl_q <= `TZM_RST_CTRL;
		end else if (wr_ok) begin
			case (REG_ADDR)
				`TZM_A_COLD: begin
					cold_q <= REG_WDATA;
				end
				`TZM_A_COOL: begin
					cool_q <= REG_WDATA;
				end
				`TZM_A_WARM: begin
					warm_q <= REG_WDATA;
				end
				`TZM_A_HOT: begin
					hot_q <= REG_WDATA;
				end
				`TZM_A_ADJ: begin
					adj_q <= REG_WDATA;
				end
				`TZM_A_CTRL: begin
					ctrl_q <= REG_WDATA;
				end
				default: begin
					ctrl_q <= ctrl_q;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Bias and sample schedule
	// ----------------------------------------
	wire [24:0] per_cnt;
	wire        per_wrap;
	wire        bias_run;
	wire        bias_win;
	wire        bias_end;

	// Battery-only bias is optional; with supply it cannot be turned off
	assign bias_run = INPUT_SUPPLY_OK |
		(BATTERY_SUPPLY_OK & ctrl_q[`TZM_CTRL_BATBIAS]);
	assign bias_win = bias_run & (per_cnt < BIAS_CYC);
	assign bias_end = bias_run & (per_cnt == BIAS_CYC - 1);

	tzm_cnt #(
		.WIDTH (25),
		.MAX   (PERIOD_CYC)
	) u_period (
		.clk   (CLK),
		.rst_b (RST_B),
		.en    (bias_run),
		.clr   (~bias_run),
		.cnt   (per_cnt),
		.wrap  (per_wrap)
	);

	always @(posedge CLK) begin
		if (!RST_B) begin
			TS_BIAS_EN  <= 1'b0;
			AUX_BIAS_EN <= 1'b0;
			SAMPLE_REQ  <= 1'b0;
		end else begin
			TS_BIAS_EN  <= bias_win;
			AUX_BIAS_EN <= bias_win & aux_en;
			SAMPLE_REQ  <= bias_end;
		end
	end

	// ----------------------------------------
	// Sample capture and zone decision
	// ----------------------------------------
	wire [2:0] ts_zone_d;
	wire [2:0] aux_zone_d;

	tzm_zone u_ts_zone (
		.code    (TS_CODE[15:8]),
		.cold_th (cold_q),
		.cool_th (cool_q),
		.warm_th (warm_q),
		.hot_th  (hot_q),
		.zone    (ts_zone_d)
	);

	tzm_zone u_aux_zone (
		.code    (AUX_CODE[15:8]),
		.cold_th (cold_q),
		.cool_th (cool_q),
		.warm_th (warm_q),
		.hot_th  (hot_q),
		.zone    (aux_zone_d)
	);

	wire ts_take  = TS_DONE;
	wire aux_take = AUX_DONE & aux_en;
	wire ts_chg   = ts_take & (!ts_valid_q | (ts_zone_d != ts_zone_q));
	wire aux_chg  = aux_take &
		(!aux_valid_q | (aux_zone_d != aux_zone_q));

	always @(posedge CLK) begin
		if (!RST_B) begin
			ts_res_q    <= 16'h0000;
			aux_res_q   <= 16'h0000;
			ts_zone_q   <= `TZM_Z_NORMAL;
			aux_zone_q  <= `TZM_Z_NORMAL;
			ts_valid_q  <= 1'b0;
			aux_valid_q <= 1'b0;
		end else begin
			if (ts_take) begin
				ts_res_q   <= TS_CODE;
				ts_zone_q  <= ts_zone_d;
				ts_valid_q <= 1'b1;
			end
			if (aux_take) begin
				aux_res_q   <= AUX_CODE;
				aux_zone_q  <= aux_zone_d;
				aux_valid_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Fault flags, cleared by reading
	// ----------------------------------------
	reg [5:0] flag_set;

	always @* begin
		flag_set = 6'h00;
		if (ts_chg) begin
			case (ts_zone_d)
				`TZM_Z_COLD: begin
					flag_set[0] = 1'b1;
				end
				`TZM_Z_COOL: begin
					flag_set[1] = 1'b1;
				end
				`TZM_Z_WARM: begin
					flag_set[2] = 1'b1;
				end
				`TZM_Z_HOT: begin
					flag_set[3] = 1'b1;
				end
				`TZM_Z_OPEN: begin
					flag_set[4] = 1'b1;
				end
				default: begin
					flag_set[0] = 1'b0;
				end
			endcase
		end
		flag_set[5] = aux_chg & aux_valid_q;
	end

	always @* begin
		if (flags_rd) begin
			flags_d = flag_set;
		end else begin
			flags_d = flags_q | flag_set;
		end
	end

	always @(posedge CLK) begin
		if (!RST_B) begin
			flags_q <= 6'h00;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------
	// Interrupt pulse, independent of profile
	// ----------------------------------------
	wire        int_event = ts_chg | (aux_chg & aux_valid_q);
	reg         pulse_on_q;
	wire [13:0] pls_cnt;
	wire        pls_wrap;

	tzm_cnt #(
		.WIDTH (14),
		.MAX   (PULSE_CYC)
	) u_pulse (
		.clk   (CLK),
		.rst_b (RST_B),
		.en    (pulse_on_q),
		.clr   (int_event & !pulse_on_q),
		.cnt   (pls_cnt),
		.wrap  (pls_wrap)
	);

	// A crossing during a running pulse is merged into it
	always @(posedge CLK) begin
		if (!RST_B) begin
			pulse_on_q <= 1'b0;
			INT_PULSE  <= 1'b0;
		end else begin
			if (int_event & !pulse_on_q) begin
				pulse_on_q <= 1'b1;
			end else if (pls_wrap) begin
				pulse_on_q <= 1'b0;
			end
			INT_PULSE <= (int_event & !pulse_on_q) |
				(pulse_on_q & !pls_wrap);
		end
	end

	// ----------------------------------------
	// Charger control
	// ----------------------------------------
	wire       z_cold = ts_valid_q & (ts_zone_q == `TZM_Z_COLD);
	wire       z_cool = ts_valid_q & (ts_zone_q == `TZM_Z_COOL);
	wire       z_warm = ts_valid_q & (ts_zone_q == `TZM_Z_WARM);
	wire       z_hot  = ts_valid_q & (ts_zone_q == `TZM_Z_HOT);
	wire       z_open = ts_valid_q & (ts_zone_q == `TZM_Z_OPEN);
	wire       susp_d = mode_on & (z_cold | z_hot);
	wire [3:0] scale  = `TZM_SCALE_FULL -
		{1'b0, adj_q[`TZM_ADJ_SCALE]};
	wire [11:0] prod  = FAST_CHARGE_CURRENT_CODE * scale;
	reg  [7:0]  cur_d;

	always @* begin
		if (mode_four & z_cool) begin
			cur_d = prod[10:3];
		end else begin
			cur_d = FAST_CHARGE_CURRENT_CODE;
		end
	end

	always @(posedge CLK) begin
		if (!RST_B) begin
			CHARGE_SUSPEND       <= 1'b0;
			SAFETY_TIMER_SUSPEND <= 1'b0;
			CHARGE_DISABLE       <= 1'b0;
			CHARGE_CURRENT_CODE  <= 8'h00;
			VREG_REDUCE          <= 1'b0;
			VREG_ADJ_CODE        <= 3'h0;
		end else begin
			CHARGE_SUSPEND       <= susp_d;
			SAFETY_TIMER_SUSPEND <= susp_d;
			CHARGE_DISABLE       <= mode_on & z_open;
			CHARGE_CURRENT_CODE  <= cur_d;
			VREG_REDUCE          <= mode_four & z_warm;
			if (mode_four & z_warm) begin
				VREG_ADJ_CODE <= adj_q[`TZM_ADJ_VREG];
			end else begin
				VREG_ADJ_CODE <= 3'h0;
			end
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	always @* begin
		case (REG_ADDR)
			`TZM_A_COLD: begin
				rdata_d = cold_q;
			end
			`TZM_A_COOL: begin
				rdata_d = cool_q;
			end
			`TZM_A_WARM: begin
				rdata_d = warm_q;
			end
			`TZM_A_HOT: begin
				rdata_d = hot_q;
			end
			`TZM_A_ADJ: begin
				rdata_d = adj_q;
			end
			`TZM_A_CTRL: begin
				rdata_d = ctrl_q;
			end
			`TZM_A_FLAGS: begin
				rdata_d = {2'b00, flags_q};
			end
			`TZM_A_ZONE: begin
				rdata_d = {ts_valid_q, aux_zone_q, 1'b0, ts_zone_q};
			end
			`TZM_A_TS_HI: begin
				rdata_d = ts_res_q[15:8];
			end
			`TZM_A_TS_LO: begin
				rdata_d = ts_res_q[7:0];
			end
			`TZM_A_AUX_HI: begin
				rdata_d = aux_res_q[15:8];
			end
			`TZM_A_AUX_LO: begin
				rdata_d = aux_res_q[7:0];
			end
			default: begin
				rdata_d = `TZM_UNMAPPED;
			end
		endcase
	end

	always @(posedge CLK) begin
		if (!RST_B) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			if (powered) begin
				REG_RDATA <= rdata_d;
			end else begin
				REG_RDATA <= `TZM_UNMAPPED;
			end
		end
	end

endmodule

/* File: test/tzm_properties.sv */
module tzm_properties #(
	parameter BIAS_CYC  = 8,
	parameter PULSE_CYC = 5
) (
	input wire       CLK,
	input wire       RST_B,
	input wire       INPUT_SUPPLY_OK,
	input wire       TS_DONE,
	input wire       AUX_DONE,
	input wire       REG_WR,
	input wire       TS_BIAS_EN,
	input wire       AUX_BIAS_EN,
	input wire       SAMPLE_REQ,
	input wire       CHARGE_SUSPEND,
	input wire       SAFETY_TIMER_SUSPEND,
	input wire       CHARGE_DISABLE,
	input wire       VREG_REDUCE,
	input wire [2:0] VREG_ADJ_CODE,
	input wire       INT_PULSE
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] bias_q;
	logic [15:0] int_q;
	// ------
	// Run lengths of bias and interrupt
	// ------
	always @(posedge CLK) begin
		if (!RST_B) begin
			bias_q <= 16'h0000;
			int_q  <= 16'h0000;
		end else begin
			bias_q <= TS_BIAS_EN ? bias_q + 16'h0001 : 16'h0000;
			int_q  <= INT_PULSE ? int_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	property p_bias_len;
		$fell(TS_BIAS_EN) && $past(SAMPLE_REQ) |-> bias_q == BIAS_CYC;
	endproperty
	a_bias_len: assert property (p_bias_len)
		else $error("bias window length wrong");
	property p_req;
		SAMPLE_REQ |-> TS_BIAS_EN ##1 !TS_BIAS_EN;
	endproperty
	a_req: assert property (p_req)
		else $error("sample request not at bias end");
	property p_keep;
		SAMPLE_REQ && INPUT_SUPPLY_OK |->
			##[1:40] (SAMPLE_REQ || !INPUT_SUPPLY_OK);
	endproperty
	a_keep: assert property (p_keep)
		else $error("periodic sampling stopped");
	property p_int_len;
		$fell(INT_PULSE) |-> int_q == PULSE_CYC;
	endproperty
	a_int_len: assert property (p_int_len)
		else $error("interrupt pulse length wrong");
	property p_int_cause;
		$rose(INT_PULSE) |-> $past(TS_DONE) || $past(AUX_DONE);
	endproperty
	a_int_cause: assert property (p_int_cause)
		else $error("interrupt without a sample");
	property p_timer;
		SAFETY_TIMER_SUSPEND == CHARGE_SUSPEND;
	endproperty
	a_timer: assert property (p_timer)
		else $error("timer and charge suspend differ");
	property p_hold;
		!$past(TS_DONE, 2) && !$past(TS_DONE) && !$past(REG_WR, 2)
			&& !$past(REG_WR)
			|-> $stable({CHARGE_SUSPEND, CHARGE_DISABLE, VREG_REDUCE});
	endproperty
	a_hold: assert property (p_hold)
		else $error("charger control changed between samples");
	property p_vreg;
		!VREG_REDUCE |-> VREG_ADJ_CODE == 3'h0;
	endproperty
	a_vreg: assert property (p_vreg)
		else $error("voltage code outside warm zone");
	property p_aux;
		AUX_BIAS_EN |-> TS_BIAS_EN;
	endproperty
	a_aux: assert property (p_aux)
		else $error("aux bias outside sampling window");
endmodule

bind tzm_top tzm_properties #(
	.BIAS_CYC (BIAS_CYC),
	.PULSE_CYC(PULSE_CYC)
) tzm_properties_i (.*);

/* File: test/tzm_adc_model.sv */
module tzm_adc_model (
	input  wire         clk,
	input  wire         sample_req,
	input  wire         ts_bias_en,
	input  wire         aux_bias_en,
	input  wire  [7:0]  level,
	output logic        ts_done = 1'b0,
	output logic [15:0] ts_code = 16'h0000,
	output logic        aux_done = 1'b0,
	output logic [15:0] aux_code = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] dly_q = 3'h0;
	logic       ts_seen_q = 1'b0;
	logic       aux_seen_q = 1'b0;
	// ------
	// TS pin voltage exists only if biased; result lines toggle when idle
	// ------
	always @(posedge clk) begin
		dly_q      <= {dly_q[1:0], sample_req};
		ts_seen_q  <= (ts_seen_q & ~ts_done) | ts_bias_en;
		aux_seen_q <= (aux_seen_q & ~aux_done) | aux_bias_en;
		ts_done    <= dly_q[2];
		aux_done   <= dly_q[2] & aux_seen_q;
		ts_code    <= dly_q[2] ? {ts_seen_q ? level : 8'h00, 8'h5a}
			: ~ts_code;
		aux_code   <= dly_q[2] ? {level, 8'ha5} : ~aux_code;
	end
endmodule

/* File: test/tzm_bench.sv */
`include "tzm_defines.vh"

module tzm_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        in_ok = 1'b0;
	logic        vbat = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  level = 8'h80;
	logic [7:0]  rdata, cur, d;
	logic [15:0] ts_code, aux_code;
	logic [2:0]  vadj;
	logic [2:0]  pz = 3'h7;
	logic [1:0]  m = 2'h0;
	logic [27:0] r;
	logic        ts_done, aux_done, ts_bias, aux_bias, req;
	logic        susp, tsusp, dis, vred, intp;
	int          error_cnt = 0;
	int          checks_done = 0;
	// Mode, code, zone, suspend/disable/reduce, current (ff: skip)
	logic [27:0] rows [17] = '{
		28'h0_80_1_4_ff, 28'h0_7c_2_0_01, 28'h0_70_2_0_01,
		28'h0_50_0_0_0c, 28'h0_38_0_0_0c, 28'h0_30_3_1_0c,
		28'h0_27_3_1_0c, 28'h0_20_4_4_ff, 28'h0_c0_1_4_ff,
		28'h0_c1_5_2_ff, 28'h1_70_2_0_0c, 28'h1_30_3_0_0c,
		28'h1_20_4_4_ff, 28'h1_c1_5_2_ff, 28'h2_80_1_0_0c,
		28'h2_c1_5_0_0c, 28'h3_20_4_0_0c};

	always #5 clk = ~clk;

	tzm_top #(.PERIOD_CYC(40), .BIAS_CYC(8), .PULSE_CYC(5)) tzm_top_i (
		.CLK(clk), .RST_B(rst_b), .INPUT_SUPPLY_OK(in_ok),
		.BATTERY_SUPPLY_OK(vbat), .FAST_CHARGE_CURRENT_CODE(8'h0c),
		.TS_DONE(ts_done), .TS_CODE(ts_code), .AUX_DONE(aux_done),
		.AUX_CODE(aux_code), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .TS_BIAS_EN(ts_bias),
		.AUX_BIAS_EN(aux_bias), .SAMPLE_REQ(req), .CHARGE_SUSPEND(susp),
		.SAFETY_TIMER_SUSPEND(tsusp), .CHARGE_DISABLE(dis),
		.CHARGE_CURRENT_CODE(cur), .VREG_REDUCE(vred),
		.VREG_ADJ_CODE(vadj), .INT_PULSE(intp));

	tzm_adc_model tzm_adc_model_i (
		.clk(clk), .sample_req(req), .ts_bias_en(ts_bias),
		.aux_bias_en(aux_bias), .level(level), .ts_done(ts_done),
		.ts_code(ts_code), .aux_done(aux_done), .aux_code(aux_code));

	// ------
	// Tasks
	// ------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdr(input logic [3:0] a, output logic [7:0] q);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask

	task automatic rc(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] q;
		rdr(a, q);
		chk(q, exp);
	endtask

	task automatic wrr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ts_done !== 1'b1 && n < 100);
		if (n >= 100)
			chk(8'h00, 8'h01);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#50000;
		error_cnt++;
		report_and_stop();
	end

	// ------
	// Sequence
	// ------
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rc(`TZM_A_COLD, 8'h7c);
		rc(`TZM_A_COOL, 8'h6d);
		rc(`TZM_A_WARM, 8'h38);
		rc(`TZM_A_HOT, 8'h27);
		rc(`TZM_A_CTRL, 8'h00);
		wrr(`TZM_A_ADJ, 8'h57);
		rc(`TZM_A_ADJ, 8'h57);
		wrr(`TZM_A_ZONE, 8'hff);
		rc(`TZM_A_ZONE, 8'h00);
		rc(4'hc, 8'hff);
		@(posedge clk);
		in_ok <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			r = rows[i];
			level <= r[23:16];
			if (r[25:24] != m)
				wrr(`TZM_A_CTRL, {6'h00, r[25:24]});
			m = r[25:24];
			wait_done();
			@(posedge clk);
			#1 chk(intp, r[14:12] != pz);
			chk({susp, dis, vred}, r[10:8]);
			chk(tsusp, r[10]);
			chk(vadj, r[8] ? 3'h5 : 3'h0);
			if (r[7:0] != 8'hff)
				chk(cur, r[7:0]);
			rc(`TZM_A_ZONE, {5'h10, r[14:12]});
			rdr(`TZM_A_FLAGS, d);
			if (r[14:12] == pz)
				chk(d, 8'h00);
			else if (r[14:12] != 3'h0)
				chk(d, 8'h01 << (r[14:12] - 1));
			pz = r[14:12];
		end
		wrr(`TZM_A_CTRL, 8'h00);
		wrr(`TZM_A_COLD, 8'h60);
		rc(`TZM_A_COLD, 8'h60);
		level <= 8'h65;
		wait_done();
		wait_done();
		@(posedge clk);
		#1 chk(susp, 1'b1);
		rc(`TZM_A_ZONE, 8'h81);
		@(posedge clk);
		in_ok <= 1'b0;
		repeat (3) @(posedge clk);
		repeat (50) begin
			@(posedge clk);
			chk(ts_bias, 1'b0);
		end
		rc(`TZM_A_TS_HI, 8'h65);
		level <= 8'h66;
		wrr(`TZM_A_CTRL, 8'h08);
		wait_done();
		rc(`TZM_A_TS_HI, 8'h66);
		level <= 8'h65;
		@(posedge clk);
		vbat <= 1'b0;
		rc(`TZM_A_TS_HI, 8'hff);
		@(posedge clk);
		in_ok <= 1'b1;
		vbat <= 1'b1;
		wrr(`TZM_A_CTRL, 8'h04);
		wait_done();
		wait_done();
		rc(`TZM_A_AUX_HI, 8'h65);
		rc(`TZM_A_AUX_LO, 8'ha5);
		level <= 8'h20;
		wait_done();
		wait_done();
		rc(`TZM_A_ZONE, 8'hc4);
		rc(`TZM_A_FLAGS, 8'h29);
		report_and_stop();
	end
endmodule
